// file: inc/eba_consts.vh
// Purpose: constants of the byte-wide nonvolatile access controller
// Assumes: io register indices are local choices, one byte per register
// Notes:   times are kept in microseconds; cycle counts derive from the clock rate
`ifndef EBA_CONSTS_VH
`define EBA_CONSTS_VH

// clock rate in MHz (50 ns period)
`define EBA_CLK_MHZ        20

// io register indices on the cpu io port
`define EBA_IDX_ADDR_LOW   2'h0
`define EBA_IDX_ADDR_HIGH  2'h1
`define EBA_IDX_DATA       2'h2
`define EBA_IDX_CTRL       2'h3

// control register field positions
`define EBA_CTRL_READ      0
`define EBA_CTRL_WRITE     1
`define EBA_CTRL_ARM       2
`define EBA_CTRL_IRQEN     3
`define EBA_CTRL_MODE_LO   4
`define EBA_CTRL_MODE_HI   5

// programming mode codes
`define EBA_MODE_ATOMIC    2'h0
`define EBA_MODE_ERASE     2'h1
`define EBA_MODE_WRITE     2'h2
`define EBA_MODE_RSVD      2'h3

// reset values and the erased byte value
`define EBA_DATA_RST       8'h00
`define EBA_ADDR_RST       9'h000
`define EBA_ERASED_BYTE    8'hFF

// memory size and address width
`define EBA_MEM_BYTES      512
`define EBA_AW             9

// programming times in microseconds
`define EBA_T_ATOMIC_US    3400
`define EBA_T_SPLIT_US     1800

// cpu stall and arm window in clock cycles
`define EBA_STALL_READ     3'h4
`define EBA_STALL_WRITE    3'h2
`define EBA_ARM_CYCLES     3'h4

// programming timer width
`define EBA_TW             17

`endif

// file: verilog/eba_ctrl.v
// Purpose: cpu side access controller for a 512 byte on-chip data store
// Assumes: cpu io port on the same clock; flash store flag is on-clock logic
// Notes:   programming engine runs on por_n so a busy cycle survives arst_n
`timescale 1ns/1ns
`include "eba_consts.vh"

// How it works
// [RQ1] 512 single bytes, linear address 0..511 from a 9-bit address field.
// [RQ2] address, data and control registers sit on the cpu io register port.
// [RQ3] a read strobe halts the cpu for four clock cycles.
// [RQ4] an accepted write strobe halts the cpu for two clock cycles.
// [RQ5] address bits 15..9 and control bits 7..6 read as zero.
// [RQ6] software must load a valid address before any access.
// [RQ7] data register feeds writes, receives reads, resets to zero.
// [RQ8] mode field picks atomic, erase only or write only; code 11 reserved.
// [RQ9] mode field writes are ignored while the write strobe is set.
// [RQ10] reset clears mode field unless programming is still running.
// [RQ11] ready request needs its enable and the cpu global interrupt enable.
// [RQ12] ready request is a level while idle, never during write or flash store.
// [RQ13] write strobe within four cycles of arming starts programming.
// [RQ14] write strobe without arm has no effect.
// [RQ15] hardware clears the arm bit four cycles after software sets it.
// [RQ16] device times programming itself and shows completion to software.
// [RQ17] write strobe bit clears by hardware when programming time elapses.
// [RQ18] read strobe loads the addressed byte into the data register at once.
// [RQ19] no read and no address change while a write is running.
// [RQ20] no programming start while the cpu is storing to flash.
// [RQ21] write strobe bit stays set as busy flag until programming ends.
// [RQ22] software keeps interrupts off between arming and write strobe.
module eba_ctrl #(
  parameter [`EBA_TW-1:0] ATOMIC_CYC = `EBA_T_ATOMIC_US * `EBA_CLK_MHZ,
  parameter [`EBA_TW-1:0] SPLIT_CYC  = `EBA_T_SPLIT_US * `EBA_CLK_MHZ
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       por_n,
  input  wire [1:0] io_idx,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       cpu_int_enable,
  input  wire       flash_store_active,
  output reg        cpu_halt,
  output reg        ready_irq
);

  // byte store; no reset, contents are nonvolatile by intent
  reg [7:0]             mem_r [0:`EBA_MEM_BYTES-1];

  // software visible registers, system reset domain
  reg [`EBA_AW-1:0]     rom_byte_address_r;
  reg [7:0]             rom_data_byte_r;
  reg                   ready_irq_enable_r;
  reg                   master_write_arm_r;
  reg [2:0]             arm_cnt_r;
  reg [2:0]             halt_cnt_r;
  reg                   rst_hold_r;

  // programming engine, power-on reset domain
  reg                   busy_r;
  reg [1:0]             program_mode_field_r;
  reg [`EBA_TW-1:0]     prog_timer_r;
  reg [`EBA_AW-1:0]     prog_addr_r;
  reg [7:0]             prog_data_r;

  // decoded io writes
  wire wr_addr_lo = io_wr && (io_idx == `EBA_IDX_ADDR_LOW);
  wire wr_addr_hi = io_wr && (io_idx == `EBA_IDX_ADDR_HIGH);
  wire wr_data    = io_wr && (io_idx == `EBA_IDX_DATA);
  wire wr_ctrl    = io_wr && (io_idx == `EBA_IDX_CTRL);

  // strobe requests from the written control byte
  wire read_req   = wr_ctrl && io_wdata[`EBA_CTRL_READ];
  wire write_req  = wr_ctrl && io_wdata[`EBA_CTRL_WRITE];
  wire arm_req    = wr_ctrl && io_wdata[`EBA_CTRL_ARM];

  // a write starts only with the arm bit still live from an earlier write;
  // reserved mode and a running flash store refuse the start silently
  wire write_go   = write_req && master_write_arm_r && !busy_r           // see [RQ13] see [RQ14]
                    && !flash_store_active                               // see [RQ20]
                    && (program_mode_field_r != `EBA_MODE_RSVD);         // see [RQ8]

  // reads are refused while programming; the stall is refused with them
  wire read_go    = read_req && !busy_r;                                 // see [RQ19]

  // timer reload picked by mode
  wire [`EBA_TW-1:0] prog_len = (program_mode_field_r == `EBA_MODE_ATOMIC) ?
                                ATOMIC_CYC : SPLIT_CYC;                  // see [RQ8]

  wire prog_done  = busy_r && (prog_timer_r == {`EBA_TW{1'b0}});

  // control byte as read back; read strobe always reads zero
  wire [7:0] ctrl_view = {2'b00,                                         // see [RQ5]
                          program_mode_field_r,
                          ready_irq_enable_r,
                          master_write_arm_r,
                          busy_r,                                        // see [RQ21]
                          1'b0};

  reg [2:0] halt_cnt_nxt;
  reg [7:0] io_rdata_nxt;

  // stall counter load: read wins if both strobes share one write
  always @* begin
    halt_cnt_nxt = halt_cnt_r;
    if (read_go) begin
      halt_cnt_nxt = `EBA_STALL_READ;                                    // see [RQ3]
    end else if (write_go) begin
      halt_cnt_nxt = `EBA_STALL_WRITE;                                   // see [RQ4]
    end else if (halt_cnt_r != 3'h0) begin
      halt_cnt_nxt = halt_cnt_r - 3'h1;
    end
  end

  // io read mux; unused high address bits read as zero
  always @* begin
    case (io_idx)
      `EBA_IDX_ADDR_LOW:  io_rdata_nxt = rom_byte_address_r[7:0];
      `EBA_IDX_ADDR_HIGH: io_rdata_nxt = {7'h00, rom_byte_address_r[8]}; // see [RQ5]
      `EBA_IDX_DATA:      io_rdata_nxt = rom_data_byte_r;
      default:            io_rdata_nxt = ctrl_view;
    endcase
  end

  // reset marker: high through reset and one edge past release, so the
  // engine domain can see the reset without sampling the raw pin
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_hold_r <= 1'b1;
    end else begin
      rst_hold_r <= 1'b0;
    end
  end

  // address register; frozen while programming runs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_byte_address_r <= `EBA_ADDR_RST;                               // see [RQ6]
    end else if (!busy_r) begin                                          // see [RQ19]
      if (wr_addr_lo) begin
        rom_byte_address_r[7:0] <= io_wdata;                             // see [RQ1]
      end
      if (wr_addr_hi) begin
        rom_byte_address_r[8] <= io_wdata[0];
      end
    end
  end

  // data register: software writes it, a read strobe loads it at once
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_data_byte_r <= `EBA_DATA_RST;                                  // see [RQ7]
    end else if (read_go) begin
      rom_data_byte_r <= mem_r[rom_byte_address_r];                      // see [RQ18]
    end else if (wr_data) begin
      rom_data_byte_r <= io_wdata;                                       // see [RQ7]
    end
  end

  // interrupt enable and the self-clearing arm bit; a fresh arm write
  // restarts the window, any other control write leaves the arm alone
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_irq_enable_r <= 1'b0;
      master_write_arm_r <= 1'b0;
      arm_cnt_r          <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ready_irq_enable_r <= io_wdata[`EBA_CTRL_IRQEN];                 // see [RQ11]
      end
      if (arm_req) begin
        master_write_arm_r <= 1'b1;
        arm_cnt_r          <= `EBA_ARM_CYCLES;
      end else if (arm_cnt_r == 3'h1) begin
        master_write_arm_r <= 1'b0;                                      // see [RQ15]
        arm_cnt_r          <= 3'h0;
      end else if (arm_cnt_r != 3'h0) begin
        arm_cnt_r          <= arm_cnt_r - 3'h1;
      end
    end
  end

  // cpu stall, io read data and ready request, all registered outputs
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_cnt_r <= 3'h0;
      cpu_halt   <= 1'b0;
      io_rdata   <= 8'h00;
      ready_irq  <= 1'b0;
    end else begin
      halt_cnt_r <= halt_cnt_nxt;
      cpu_halt   <= (halt_cnt_nxt != 3'h0);                              // see [RQ3] see [RQ4]
      if (io_rd) begin
        io_rdata <= io_rdata_nxt;                                        // see [RQ2]
      end
      // level request: idle engine, no flash store, both enables set
      ready_irq  <= ready_irq_enable_r && cpu_int_enable                 // see [RQ11]
                    && !busy_r && !write_go && !flash_store_active;      // see [RQ12]
    end
  end

  // programming engine; survives a system reset so a started cycle ends
  // cleanly, trading a second reset input for no torn bytes
  always @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      busy_r               <= 1'b0;
      program_mode_field_r <= `EBA_MODE_ATOMIC;
      prog_timer_r         <= {`EBA_TW{1'b0}};
      prog_addr_r          <= `EBA_ADDR_RST;
      prog_data_r          <= `EBA_DATA_RST;
    end else begin
      if (rst_hold_r) begin
        if (!busy_r) begin
          program_mode_field_r <= `EBA_MODE_ATOMIC;                      // see [RQ10]
        end
      end else if (wr_ctrl && !busy_r && !write_go) begin
        // a starting write keeps the old mode, so the length and the cell
        // action of that cycle always agree
        program_mode_field_r <= io_wdata[`EBA_CTRL_MODE_HI:`EBA_CTRL_MODE_LO]; // see [RQ9]
      end
      if (write_go && !rst_hold_r) begin
        busy_r       <= 1'b1;                                            // see [RQ21]
        prog_timer_r <= prog_len - {{(`EBA_TW-1){1'b0}}, 1'b1};          // see [RQ16]
        prog_addr_r  <= rom_byte_address_r;
        prog_data_r  <= rom_data_byte_r;                                 // see [RQ7]
      end else if (prog_done) begin
        busy_r       <= 1'b0;                                            // see [RQ17]
      end else if (busy_r) begin
        prog_timer_r <= prog_timer_r - {{(`EBA_TW-1){1'b0}}, 1'b1};
      end
    end
  end

  // cell update at the end of the programming time
  always @(posedge clk) begin
    if (prog_done) begin
      case (program_mode_field_r)
        `EBA_MODE_ATOMIC: mem_r[prog_addr_r] <= prog_data_r;             // see [RQ8]
        `EBA_MODE_ERASE:  mem_r[prog_addr_r] <= `EBA_ERASED_BYTE;
        `EBA_MODE_WRITE:  mem_r[prog_addr_r] <= mem_r[prog_addr_r] & prog_data_r;
        default:          mem_r[prog_addr_r] <= mem_r[prog_addr_r];
      endcase
    end
  end

endmodule

// file: dv/eba_ctrl_checker.sv
// Purpose: port assertions for the byte access controller
// Assumes: control index comes from the shared constants; strobe bits are fixed at bits 1..0
// Notes:   busy is hidden at the ports, so stalls are keyed off the halt edge
`timescale 1ns/1ns
`include "eba_consts.vh"
module eba_ctrl_checker (
  input wire       clk,
  input wire       arst_n,
  input wire [1:0] io_idx,
  input wire       io_wr,
  input wire       io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire       cpu_int_enable,
  input wire       flash_store_active,
  input wire       cpu_halt,
  input wire       ready_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // decoded strobes, so $past sees plain signals
  wire ctl_wr = io_wr && io_idx == `EBA_IDX_CTRL;
  wire stb_wr = ctl_wr && io_wdata[1:0] != 2'h0;
  wire rd_wr  = ctl_wr && io_wdata[0];
  wire hi_rd  = io_rd && io_idx == `EBA_IDX_ADDR_HIGH;
  wire ct_rd  = io_rd && io_idx == `EBA_IDX_CTRL;
  chk_halt_cause:
    assert property ($rose(cpu_halt) |-> $past(stb_wr)) else $error("halt without strobe");
  chk_read_stall:
    assert property ($rose(cpu_halt) && $past(rd_wr) |-> cpu_halt [*4] ##1 !cpu_halt)
    else $error("read stall length wrong");
  chk_write_stall:
    assert property ($rose(cpu_halt) && !$past(rd_wr) |-> cpu_halt [*2] ##1 !cpu_halt)
    else $error("write stall length wrong");
  chk_busy_no_irq:
    assert property ($rose(cpu_halt) && !$past(rd_wr) |=> !ready_irq [*2])
    else $error("ready request during write");
  chk_irq_global_en:
    assert property (ready_irq |-> $past(cpu_int_enable)) else $error("request without enable");
  chk_irq_flash_off:
    assert property (flash_store_active |=> !ready_irq) else $error("request during flash store");
  chk_rdata_hold:
    assert property (!$past(io_rd) |-> $stable(io_rdata)) else $error("read data moved");
  chk_addr_rsvd:
    assert property ($past(hi_rd) |-> io_rdata[7:1] == 7'h00) else $error("address bits set");
  chk_ctrl_rsvd:
    assert property ($past(ct_rd) |-> io_rdata[7:6] == 2'h0 && !io_rdata[0])
    else $error("control reserved bits set");
endmodule

// file: dv/eba_cpu_model.sv
// Purpose: processor core model issuing io register cycles
// Assumes: one access at a time; the core waits out any stall first
// Notes:   released index and data show the inverse, never the last value
`timescale 1ns/1ns
module eba_cpu_model (
  input  wire       clk,
  input  wire       cpu_halt,
  input  wire [7:0] io_rdata,
  output reg  [1:0] io_idx,
  output reg        io_wr,
  output reg        io_rd,
  output reg  [7:0] io_wdata
);
  // a halted core issues nothing; each access is a one-cycle strobe
  task go(input [1:0] idx, input w, input [7:0] d);
    begin
      @(posedge clk);
      while (cpu_halt) @(posedge clk);
      io_idx <= idx;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= !w;
      @(posedge clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_idx <= ~idx;
      io_wdata <= ~d;
    end
  endtask
  task wr(input [1:0] idx, input [7:0] d);
    go(idx, 1'b1, d);
  endtask
  task rd(input [1:0] idx, output [7:0] d);
    begin
      go(idx, 1'b0, 8'h00);
      @(posedge clk);
      #1 d = io_rdata;
    end
  endtask
  // idle bus before the first access
  initial begin
    io_idx = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
endmodule

// file: dv/tb.sv
// Purpose: self-checking bench for the byte access controller
// Assumes: short programming counts of 20 and 10 cycles
// Notes:   por_n is only pulsed at power-up so busy can outlive arst_n
`timescale 1ns/1ns
`include "eba_consts.vh"
module tb;
  reg        clk;
  reg        arst_n;
  reg        por_n;
  reg        int_en;
  reg        flash;
  wire [1:0] io_idx;
  wire       io_wr;
  wire       io_rd;
  wire [7:0] io_wdata;
  wire [7:0] io_rdata;
  wire       cpu_halt;
  wire       ready_irq;
  integer    err_total;
  integer    cmp_count;
  eba_ctrl #(.ATOMIC_CYC(17'd20), .SPLIT_CYC(17'd10)) eba_ctrl_i (.clk(clk), .arst_n(arst_n),
    .por_n(por_n), .io_idx(io_idx), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_int_enable(int_en), .flash_store_active(flash),
    .cpu_halt(cpu_halt), .ready_irq(ready_irq));
  eba_cpu_model eba_cpu_model_i (.clk(clk), .cpu_halt(cpu_halt), .io_rdata(io_rdata),
    .io_idx(io_idx), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rdchk(input [1:0] idx, input [7:0] exp);
    reg [7:0] d;
    begin
      eba_cpu_model_i.rd(idx, d);
      chk(d, exp);
    end
  endtask
  task wr(input [1:0] idx, input [7:0] d);
    eba_cpu_model_i.wr(idx, d);
  endtask
  // address before data, as software must; mode set apart from the strobe
  task bw(input [8:0] a, input [7:0] d, input [1:0] m);
    begin
      wr(`EBA_IDX_ADDR_LOW, a[7:0]);
      wr(`EBA_IDX_ADDR_HIGH, {7'h00, a[8]});
      wr(`EBA_IDX_DATA, d);
      wr(`EBA_IDX_CTRL, {2'h0, m, 4'h0});
      wr(`EBA_IDX_CTRL, {2'h0, m, 4'h4});
      wr(`EBA_IDX_CTRL, {2'h0, m, 4'h2});
    end
  endtask
  // data cleared first so a missed read shows up
  task br(input [7:0] exp);
    begin
      wr(`EBA_IDX_DATA, 8'h00);
      wr(`EBA_IDX_CTRL, 8'h01);
      rdchk(`EBA_IDX_DATA, exp);
    end
  endtask
  task wait_idle;
    reg [7:0] d;
    integer n;
    begin
      d = 8'h02;
      for (n = 0; n < 40 && d[1]; n = n + 1)
        eba_cpu_model_i.rd(`EBA_IDX_CTRL, d);
      chk({7'h00, d[1]}, 8'h00);
    end
  endtask
  task t_reset;
    begin
      rdchk(`EBA_IDX_CTRL, 8'h00);
      rdchk(`EBA_IDX_DATA, 8'h00);
      wr(`EBA_IDX_ADDR_HIGH, 8'hFF);
      rdchk(`EBA_IDX_ADDR_HIGH, 8'h01);
      wr(`EBA_IDX_CTRL, 8'hC8);
      rdchk(`EBA_IDX_CTRL, 8'h08);
    end
  endtask
  // strobe without arm, then one cycle past the arm window
  task t_refuse;
    begin
      wr(`EBA_IDX_CTRL, 8'h02);
      rdchk(`EBA_IDX_CTRL, 8'h00);
      wr(`EBA_IDX_CTRL, 8'h04);
      repeat (3) @(posedge clk);
      wr(`EBA_IDX_CTRL, 8'h02);
      rdchk(`EBA_IDX_CTRL, 8'h00);
    end
  endtask
  task t_atomic;
    begin
      bw(9'h1FF, 8'hA5, `EBA_MODE_ATOMIC);
      rdchk(`EBA_IDX_CTRL, 8'h02);
      wr(`EBA_IDX_ADDR_LOW, 8'h00);
      wr(`EBA_IDX_CTRL, 8'h12);
      rdchk(`EBA_IDX_CTRL, 8'h02);
      wait_idle;
      br(8'hA5);
    end
  endtask
  task t_split;
    begin
      bw(9'h055, 8'h3C, `EBA_MODE_ERASE);
      wait_idle;
      br(8'hFF);
      bw(9'h055, 8'h3C, `EBA_MODE_WRITE);
      wait_idle;
      br(8'h3C);
      bw(9'h055, 8'h00, `EBA_MODE_RSVD);
      repeat (4) @(posedge clk);
      rdchk(`EBA_IDX_CTRL, 8'h30);
    end
  endtask
  task t_irq;
    begin
      wr(`EBA_IDX_CTRL, 8'h08);
      @(posedge clk) int_en <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h00, ready_irq}, 8'h01);
      // armed write with the request enabled: level drops while busy
      wr(`EBA_IDX_CTRL, 8'h0C);
      wr(`EBA_IDX_CTRL, 8'h0A);
      repeat (2) @(posedge clk);
      chk({7'h00, ready_irq}, 8'h00);
      wait_idle;
      repeat (2) @(posedge clk);
      chk({7'h00, ready_irq}, 8'h01);
      @(posedge clk) flash <= 1'b1;
      wr(`EBA_IDX_CTRL, 8'h0C);
      wr(`EBA_IDX_CTRL, 8'h0A);
      chk({7'h00, ready_irq}, 8'h00);
      repeat (4) @(posedge clk);
      rdchk(`EBA_IDX_CTRL, 8'h08);
      @(posedge clk) flash <= 1'b0;
      int_en <= 1'b0;
      repeat (2) @(posedge clk);
      chk({7'h00, ready_irq}, 8'h00);
    end
  endtask
  // a system reset mid-write keeps the mode; an idle one clears it
  task t_reset_busy;
    begin
      bw(9'h010, 8'h00, `EBA_MODE_ERASE);
      @(posedge clk) arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(`EBA_IDX_CTRL, 8'h12);
      wait_idle;
      @(posedge clk) arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(`EBA_IDX_CTRL, 8'h00);
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    por_n = 1'b0;
    int_en = 1'b0;
    flash = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset;
    t_refuse;
    t_atomic;
    t_split;
    t_irq;
    t_reset_busy;
    results;
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    err_total = err_total + 1;
    results;
  end
endmodule
bind eba_ctrl eba_ctrl_checker eba_ctrl_checker_i (.clk(clk), .arst_n(arst_n),
  .io_idx(io_idx), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .cpu_int_enable(cpu_int_enable), .flash_store_active(flash_store_active),
  .cpu_halt(cpu_halt), .ready_irq(ready_irq));
